// ===== logic/blc_pkg.sv
// Shared constants and types for the button and indicator controller.
// Assumes one 50 MHz clock and an APB master with 32-bit data.
`default_nettype none

package blc_pkg;

   // =====================================================================
   // Clock and timing
   // =====================================================================
   localparam longint unsigned CLK_HZ        = 64'd50_000_000;
   localparam longint unsigned LONG_HOLD_MS  = 64'd3000;
   localparam longint unsigned BLINK1_MS     = 64'd1000;
   localparam longint unsigned BLINK2_MS     = 64'd500;
   localparam longint unsigned FAULT_US      = 64'd256;
   localparam longint unsigned HIB_MIN       = 64'd5;
   localparam longint unsigned DEBOUNCE_MS   = 64'd10;
   // Derived cycle counts (half periods toggle the blink phase)
   localparam longint unsigned LONG_HOLD_CYC = CLK_HZ / 1000 * LONG_HOLD_MS;
   localparam longint unsigned BLINK1_HALF   = CLK_HZ * BLINK1_MS / 2000;
   localparam longint unsigned BLINK2_HALF   = CLK_HZ * BLINK2_MS / 2000;
   localparam longint unsigned FAULT_HALF    = CLK_HZ * FAULT_US / 2_000_000;
   localparam longint unsigned HIB_CYC       = CLK_HZ * 60 * HIB_MIN;
   localparam longint unsigned DEBOUNCE_CYC  = CLK_HZ * DEBOUNCE_MS / 1000;
   localparam logic [4:0]      RST_PULSE_CYC = 5'h10;

   // =====================================================================
   // Buttons
   // =====================================================================
   localparam int BTN_WAKE = 0;
   localparam int BTN_SCAN = 1;
   localparam int BTN_RST  = 2;
   localparam int BTN_N    = 3;

   // =====================================================================
   // Register map
   // =====================================================================
   localparam logic [7:0]  OFS_CTRL     = 8'h00;
   localparam logic [7:0]  OFS_STATUS   = 8'h04;
   localparam logic [7:0]  OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0]  OFS_IRQ_MASK = 8'h0C;
   localparam logic [31:0] CTRL_RST_VAL = 32'h0000_0001;
   localparam logic [5:0]  MASK_RST_VAL = 6'h00;

   // Control word: auto_hib steers the idle timer
   typedef struct packed {
      logic [28:0] rsvd;
      logic        radio_off;
      logic        fw_done;
      logic        auto_hib;
   } blc_ctrl_t;

   // Indicator set
   typedef struct packed {
      logic red;
      logic yellow;
      logic blue;
      logic green;
   } blc_led_t;

   // Status word as read by software
   typedef struct packed {
      logic [22:0] rsvd;
      blc_led_t    led;
      logic        rst_act;
      logic        link_up;
      logic        radio;
      logic        scanning;
      logic        awake;
   } blc_stat_word_t;

   // Sticky event bits, same layout in status and mask
   typedef struct packed {
      logic reset_done;
      logic hib;
      logic radio;
      logic scan_end;
      logic scan_start;
      logic wake;
   } blc_irq_t;

   // Flags from the rest of the system, same clock
   typedef struct packed {
      logic [7:0] sys_err;
      logic       link_err;
      logic       link_up;
      logic       scan_err;
      logic       scan_done;
      logic       charging;
      logic       batt_fault;
      logic       busy;
   } blc_sys_t;

   typedef enum logic [1:0] {
      MODE_HIB = 2'b01,
      MODE_ACT = 2'b10
   } blc_mode_t;

   // Debouncer state
   typedef struct packed {
      logic        s1;
      logic        s2;
      logic        lvl;
      logic [19:0] cnt;
   } blc_db_state_t;

   // Controller state
   typedef struct packed {
      blc_mode_t   mode;
      logic        scanning;
      logic        radio;
      logic [4:0]  rst_cnt;
      logic        fw_rst;
      logic        reconnect;
      logic        rst_out_n;
      logic [2:0]  btn_prev;
      logic [27:0] hold_cnt;
      logic [33:0] hib_cnt;
      logic [27:0] c1;
      logic [27:0] c2;
      logic [27:0] cf;
      logic        ph1;
      logic        ph2;
      logic        phf;
      blc_led_t    led;
      blc_ctrl_t   ctrl;
      blc_irq_t    irq_stat;
      blc_irq_t    irq_mask;
      logic        irq;
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } blc_state_t;

endpackage

`default_nettype wire

// ===== logic/blc_debounce.sv
// Two-flop synchroniser and debouncer for one push button.
// Assumes an active-high raw button level from a pin.
`default_nettype none

module blc_debounce #(
   parameter logic [19:0] DB_CYC = 20'(blc_pkg::DEBOUNCE_CYC)
) (
   input  wire logic mclk,      // System clock
   input  wire logic rst_n,     // Async reset, active low
   input  wire logic btn_raw,   // Raw button pin
   output var  logic btn_level  // Debounced level
);

   blc_pkg::blc_db_state_t q;
   blc_pkg::blc_db_state_t d;

   // =====================================================================
   // Synchronise, then accept a level only after it stays stable
   // =====================================================================
   always_comb begin
      d = q;
      d.s1 = btn_raw;
      d.s2 = q.s1;
      if (q.s2 == q.lvl) begin
         d.cnt = 20'h0;
      end else if (q.cnt >= DB_CYC - 20'h1) begin
         d.lvl = q.s2;
         d.cnt = 20'h0;
      end else begin
         d.cnt = q.cnt + 20'h1;
      end
   end

   // State register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign btn_level = q.lvl;

endmodule

`default_nettype wire

// ===== logic/blc_top.sv
// Front-panel button and indicator controller with APB registers.
// Assumes one 50 MHz clock, buttons on pins, system flags on mclk.
//
// Design decisions made here: the address map and the APB register port.
`default_nettype none

module blc_top #(
   parameter logic [27:0] LONG_HOLD  = 28'(blc_pkg::LONG_HOLD_CYC),
   parameter logic [27:0] BLINK1_H   = 28'(blc_pkg::BLINK1_HALF),
   parameter logic [27:0] BLINK2_H   = 28'(blc_pkg::BLINK2_HALF),
   parameter logic [27:0] FAULT_H    = 28'(blc_pkg::FAULT_HALF),
   parameter logic [33:0] HIB_IDLE   = 34'(blc_pkg::HIB_CYC),
   parameter logic [19:0] DB_CYC     = 20'(blc_pkg::DEBOUNCE_CYC)
) (
   input  wire logic               mclk,          // System clock
   input  wire logic               rst_n,         // Async reset, low
   input  wire logic [2:0]         btn_raw,       // Wake, scan, reset pins
   input  wire blc_pkg::blc_sys_t  sys_flags,     // System status flags
   input  wire logic               psel,          // APB select
   input  wire logic               penable,       // APB enable
   input  wire logic               pwrite,        // APB write
   input  wire logic [7:0]         paddr,         // APB byte address
   input  wire logic [31:0]        pwdata,        // APB write data
   output var  logic [31:0]        prdata,        // APB read data
   output var  logic               pready,        // APB ready
   output var  logic               pslverr,       // APB error
   output var  blc_pkg::blc_led_t  led,           // Indicator drives
   output var  logic               lamp_en,       // Lamp enable
   output var  logic               radio_pwr,     // Wireless power
   output var  logic               sys_awake,     // System out of standby
   output var  logic               sys_rst_n_out, // Hardware reset, low
   output var  logic               host_reconnect,// Reconnect request pulse
   output var  logic               irq            // Interrupt level
);

   blc_pkg::blc_state_t q;
   blc_pkg::blc_state_t d;
   logic [2:0]          db;
   logic [2:0]          rise;
   logic [2:0]          fall;
   logic                acc;
   logic                hit;
   logic                short_rel;
   logic                long_rel;
   logic                activity;
   logic                in_rst;
   logic                active;

   // =====================================================================
   // Helpers
   // =====================================================================
   // Free-running half-period counter; top bit marks the wrap
   function automatic logic [28:0] blc_tick(input logic [27:0] c,
                                            input logic [27:0] lim);
      if (c >= lim - 28'h1) begin
         blc_tick = {1'b1, 28'h0};
      end else begin
         blc_tick = {1'b0, c + 28'h1};
      end
   endfunction

   // =====================================================================
   // Button conditioning
   // =====================================================================
   for (genvar i = 0; i < blc_pkg::BTN_N; i++) begin : g_btn
      blc_debounce #(
         .DB_CYC    (DB_CYC)
      ) u_db (
         .mclk      (mclk),
         .rst_n     (rst_n),
         .btn_raw   (btn_raw[i]),
         .btn_level (db[i])
      );
   end

   // Debounced edges and press classification
   assign rise      = db & ~q.btn_prev;
   assign fall      = ~db & q.btn_prev;
   assign in_rst    = (q.rst_cnt != 5'h0);
   assign active    = (q.mode == blc_pkg::MODE_ACT) && !in_rst;
   assign short_rel = fall[blc_pkg::BTN_SCAN] && (q.hold_cnt < LONG_HOLD);
   assign long_rel  = fall[blc_pkg::BTN_SCAN] && (q.hold_cnt >= LONG_HOLD);
   assign activity  = (|rise) || q.scanning || sys_flags.busy ||
                      (q.radio && sys_flags.link_up);

   // APB access phase completes on the edge that samples pready high
   assign acc = psel && penable && q.pready;
   assign hit = (paddr == blc_pkg::OFS_CTRL) ||
                (paddr == blc_pkg::OFS_STATUS) ||
                (paddr == blc_pkg::OFS_IRQ_STAT) ||
                (paddr == blc_pkg::OFS_IRQ_MASK);

   // =====================================================================
   // Next-state logic
   // =====================================================================
   always_comb begin
      blc_pkg::blc_irq_t   ev;
      blc_pkg::blc_irq_t   clr;
      blc_pkg::blc_ctrl_t  wctl;
      blc_pkg::blc_stat_word_t sw;
      logic [28:0]         t1;
      logic [28:0]         t2;
      logic [28:0]         tf;
      ev   = '0;
      clr  = '0;
      wctl = blc_pkg::blc_ctrl_t'(pwdata);
      sw   = '0;
      t1   = blc_tick(q.c1, BLINK1_H);
      t2   = blc_tick(q.c2, BLINK2_H);
      tf   = blc_tick(q.cf, FAULT_H);
      d    = q;
      d.btn_prev  = db;
      d.reconnect = 1'b0;
      d.ctrl.fw_done   = 1'b0;
      d.ctrl.radio_off = 1'b0;

      // Blink phase generators
      d.c1 = t1[27:0];
      d.c2 = t2[27:0];
      d.cf = tf[27:0];
      d.ph1 = q.ph1 ^ t1[28];
      d.ph2 = q.ph2 ^ t2[28];
      d.phf = q.phf ^ tf[28];

      // Hold time between debounced press and release
      if (!db[blc_pkg::BTN_SCAN]) begin
         d.hold_cnt = 28'h0;
      end else if (q.hold_cnt < LONG_HOLD) begin
         d.hold_cnt = q.hold_cnt + 28'h1;
      end

      // Wake from standby
      if (q.mode == blc_pkg::MODE_HIB && rise[blc_pkg::BTN_WAKE]) begin
         d.mode    = blc_pkg::MODE_ACT;
         d.hib_cnt = 34'h0;
         ev.wake   = 1'b1;
      end

      // Scan and radio requests from the scan button
      if (active && short_rel && !q.scanning) begin
         d.scanning    = 1'b1;
         ev.scan_start = 1'b1;
      end
      if (active && long_rel) begin
         d.radio  = 1'b1;
         ev.radio = 1'b1;
      end
      if (q.scanning && sys_flags.scan_done) begin
         d.scanning  = 1'b0;
         ev.scan_end = 1'b1;
      end

      // Idle timer drives automatic hibernation
      if (!active || activity || !q.ctrl.auto_hib) begin
         d.hib_cnt = 34'h0;
      end else if (q.hib_cnt >= HIB_IDLE - 34'h1) begin
         d.hib_cnt  = 34'h0;
         d.mode     = blc_pkg::MODE_HIB;
         d.scanning = 1'b0;
         d.radio    = 1'b0;
         ev.hib     = 1'b1;
      end else begin
         d.hib_cnt = q.hib_cnt + 34'h1;
      end

      // Register writes and read side effects
      if (acc && hit && pwrite) begin
         if (paddr == blc_pkg::OFS_CTRL) begin
            d.ctrl.auto_hib = wctl.auto_hib;
            if (wctl.radio_off) begin
               d.radio = 1'b0;
            end
            if (wctl.fw_done && !in_rst) begin
               d.rst_cnt = blc_pkg::RST_PULSE_CYC;
               d.fw_rst  = 1'b1;
            end
         end else if (paddr == blc_pkg::OFS_IRQ_MASK) begin
            d.irq_mask = blc_pkg::blc_irq_t'(pwdata[5:0]);
         end
      end
      if (acc && !pwrite && paddr == blc_pkg::OFS_IRQ_STAT) begin
         clr = q.irq_stat;
      end

      // Hardware reset pulse from the button
      if (rise[blc_pkg::BTN_RST] && !in_rst) begin
         d.rst_cnt = blc_pkg::RST_PULSE_CYC;
         d.fw_rst  = 1'b0;
      end
      if (in_rst) begin
         d.rst_cnt  = q.rst_cnt - 5'h1;
         d.scanning = 1'b0;
         d.radio    = 1'b0;
         d.mode     = blc_pkg::MODE_ACT;
         if (q.rst_cnt == 5'h1) begin
            ev.reset_done = 1'b1;
            d.reconnect   = q.fw_rst;
            d.fw_rst      = 1'b0;
         end
      end
      d.rst_out_n = (d.rst_cnt == 5'h0);

      // Sticky events: a new event wins over the read clear
      d.irq_stat = (q.irq_stat & ~clr) | ev;
      d.irq      = |(d.irq_stat & d.irq_mask);

      // Indicators; error pulsing overrides normal patterns, except green stays off in standby
      if (q.mode != blc_pkg::MODE_ACT) begin
         d.led.green = 1'b0;
      end else if (|sys_flags.sys_err) begin
         d.led.green = q.ph2;
      end else begin
         d.led.green = q.ph1;
      end
      if (sys_flags.link_err) begin
         d.led.blue = q.ph2;
      end else if (q.radio && sys_flags.link_up) begin
         d.led.blue = q.ph1;
      end else begin
         d.led.blue = q.radio;
      end
      d.led.yellow = sys_flags.scan_err ? q.ph2 : q.scanning;
      d.led.red    = sys_flags.batt_fault ? q.phf
                                          : sys_flags.charging;

      // APB answer: one wait state, then data with pready
      d.pready  = psel && penable && !q.pready;
      d.pslverr = 1'b0;
      d.prdata  = 32'h0000_0000;
      if (psel && penable && !q.pready) begin
         d.pslverr = !hit;
         if (!pwrite) begin
            if (paddr == blc_pkg::OFS_CTRL) begin
               d.prdata = 32'(q.ctrl);
            end else if (paddr == blc_pkg::OFS_STATUS) begin
               sw.led      = q.led;
               sw.rst_act  = in_rst;
               sw.link_up  = q.radio && sys_flags.link_up;
               sw.radio    = q.radio;
               sw.scanning = q.scanning;
               sw.awake    = (q.mode == blc_pkg::MODE_ACT);
               d.prdata    = 32'(sw);
            end else if (paddr == blc_pkg::OFS_IRQ_STAT) begin
               d.prdata = {26'h0, q.irq_stat | ev};
            end else if (paddr == blc_pkg::OFS_IRQ_MASK) begin
               d.prdata = {26'h0, q.irq_mask};
            end
         end
      end
   end

   // =====================================================================
   // State register
   // =====================================================================
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         q           <= '0;
         q.mode      <= blc_pkg::MODE_ACT;
         q.rst_out_n <= 1'b1;
         q.ctrl      <= blc_pkg::blc_ctrl_t'(blc_pkg::CTRL_RST_VAL);
         q.irq_mask  <= blc_pkg::blc_irq_t'(blc_pkg::MASK_RST_VAL);
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   assign prdata         = q.prdata;
   assign pready         = q.pready;
   assign pslverr        = q.pslverr;
   assign led            = q.led;
   assign lamp_en        = q.scanning;
   assign radio_pwr      = q.radio;
   assign sys_awake      = (q.mode == blc_pkg::MODE_ACT);
   assign sys_rst_n_out  = q.rst_out_n;
   assign host_reconnect = q.reconnect;
   assign irq            = q.irq;

   // =====================================================================
   // Assertions
   // =====================================================================
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_fw_write;
      acc && pwrite && paddr == blc_pkg::OFS_CTRL && pwdata[1] && !in_rst;
   endsequence
   sequence s_rst_tail;
      !sys_rst_n_out [*8] ##1 !sys_rst_n_out [*8] ##1 sys_rst_n_out;
   endsequence

   AST_WAKE: assert property (
      q.mode == blc_pkg::MODE_HIB && rise[0] |=> sys_awake)
      else $error("wake press did not leave standby");
   AST_GREEN_OK: assert property (
      sys_awake && !(|sys_flags.sys_err) |=> led.green == $past(q.ph1))
      else $error("green not on the slow pattern");
   AST_GREEN_ERR: assert property (
      sys_awake && (|sys_flags.sys_err) |=> led.green == $past(q.ph2))
      else $error("green not on the error pattern");
   AST_SCAN: assert property (
      active && short_rel && !q.scanning && !sys_flags.scan_done
      && !rise[2] |=> lamp_en ##1
      (led.yellow || $past(sys_flags.scan_err)))
      else $error("short press did not start a scan");
   AST_HOLD: assert property (
      active && long_rel && !rise[2] && !q.scanning |=>
      radio_pwr && !lamp_en)
      else $error("long hold did not start the radio");
   AST_BLUE: assert property (
      q.radio && !sys_flags.link_up && !sys_flags.link_err |=> led.blue)
      else $error("blue not steady while advertising");
   AST_BLUE_LINK: assert property (
      q.radio && sys_flags.link_up && !sys_flags.link_err
      |=> led.blue == $past(q.ph1))
      else $error("blue not pulsing on link");
   AST_RED: assert property (
      sys_flags.batt_fault |=> led.red == $past(q.phf))
      else $error("red not pulsing on battery fault");
   AST_RST_BTN: assert property (
      rise[2] && !in_rst |=> s_rst_tail)
      else $error("reset pulse has the wrong length");
   AST_FW: assert property (
      (s_fw_write and !rise[2]) |=> s_rst_tail ##0 host_reconnect)
      else $error("no reconnect after firmware reset");
   AST_HIB: assert property (
      active && !activity && q.ctrl.auto_hib && !acc && !rise[2] &&
      q.hib_cnt == HIB_IDLE - 34'h1 |=> !sys_awake && !radio_pwr)
      else $error("idle timeout did not hibernate");

endmodule

`default_nettype wire

// ===== tb/blc_user.sv
// Front-panel user model: presses buttons for a given time.
// Assumes mclk from the bench; pins change after rising edges.
`default_nettype none

module blc_user (
   input  wire logic       mclk,    // System clock
   output var  logic [2:0] btn_raw  // Wake, scan, reset pins
);
   timeunit 1ns;
   timeprecision 1ns;

   initial btn_raw = 3'h0;

   // Hold one button for len cycles, release, then leave it alone
   task automatic press(input int b, input int len);
      @(posedge mclk) btn_raw[b] <= 1'b1;
      repeat (len) @(posedge mclk);
      btn_raw[b] <= 1'b0;
      repeat (8) @(posedge mclk);
   endtask
endmodule

`default_nettype wire

// ===== tb/blc_top_tb_top.sv
// Self-checking bench for the button and indicator controller.
// Assumes shortened timing parameters; user model drives the pins.
`default_nettype none

module blc_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   logic              mclk = 1'b0;
   logic              rst_n = 1'b0;
   logic [2:0]        btn_raw;
   blc_pkg::blc_sys_t sys_flags = '0;
   logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]        paddr = 8'h00;
   logic [31:0]       pwdata = 32'h0, prdata, rd, rv;
   logic              pready, pslverr, er;
   blc_pkg::blc_led_t led;
   logic              lamp_en, radio_pwr, sys_awake, rst_out_n, recon, irq;
   int                failures = 0, n_compared = 0, cyc = 0, lo, rc;
   integer            seed = 32'h78440021;

   blc_user i_blc_user (.mclk(mclk), .btn_raw(btn_raw));

   // Fault blink keeps its real period so the 256 us figure is checked
   blc_top #(.LONG_HOLD(28'h28), .BLINK1_H(28'h8), .BLINK2_H(28'h4),
      .HIB_IDLE(34'h64), .DB_CYC(20'h3)) i_blc_top (
      .mclk(mclk), .rst_n(rst_n), .btn_raw(btn_raw),
      .sys_flags(sys_flags), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .led(led), .lamp_en(lamp_en),
      .radio_pwr(radio_pwr), .sys_awake(sys_awake),
      .sys_rst_n_out(rst_out_n), .host_reconnect(recon), .irq(irq));

   // 50 MHz clock and hang guard
   always #10 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         failures++;
         finish_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   // One APB transfer; read data and error land in rd and er
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk) penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Cycles between two rising edges of one indicator
   task automatic per(input int b, input int exp);
      logic p;
      int   t0, i;
      p = led[b];
      t0 = -1;
      for (i = 0; i < 30000; i++) begin
         @(posedge mclk);
         if (p === 1'b0 && led[b] === 1'b1) begin
            if (t0 >= 0) break;
            t0 = i;
         end
         p = led[b];
      end
      chk(i - t0, exp);
   endtask

   // Count reset-low cycles and reconnect pulses over 80 cycles
   task automatic cnt_rst();
      lo = 0;
      rc = 0;
      repeat (80) begin
         @(posedge mclk);
         lo += (rst_out_n === 1'b0);
         rc += (recon === 1'b1);
      end
   endtask

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h1);
      apb(1'b0, 8'h10, 32'h0);
      chk(er, 1'b1);
      rv = $random(seed);
      apb(1'b1, 8'h0C, rv);
      apb(1'b0, 8'h0C, 32'h0);
      chk(rd, {26'h0, rv[5:0]});
      apb(1'b1, 8'h0C, 32'h1);
      $display("test registers done");
      per(0, 16);
      sys_flags.sys_err <= 8'h01;
      per(0, 8);
      sys_flags.sys_err <= 8'h00;
      sys_flags.charging <= 1'b1;
      repeat (3) @(posedge mclk);
      chk(led.red, 1'b1);
      sys_flags.batt_fault <= 1'b1;
      per(3, int'(2 * blc_pkg::FAULT_HALF));
      sys_flags <= '0;
      $display("test indicators done");
      repeat (130) @(posedge mclk);
      chk(sys_awake, 1'b0);
      i_blc_user.press(0, 6);
      chk(sys_awake, 1'b1);
      chk(irq, 1'b1);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd[0], 1'b1);
      @(posedge mclk);
      chk(irq, 1'b0);
      per(0, 16);
      apb(1'b1, 8'h00, 32'h0);
      repeat (200) @(posedge mclk);
      chk(sys_awake, 1'b1);
      $display("test hibernation done");
      i_blc_user.press(1, 5 + {$random(seed)} % 20);
      chk(lamp_en, 1'b1);
      chk(led.yellow, 1'b1);
      sys_flags.scan_err <= 1'b1;
      per(2, 8);
      sys_flags.scan_err <= 1'b0;
      sys_flags.scan_done <= 1'b1;
      @(posedge mclk) sys_flags.scan_done <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(lamp_en, 1'b0);
      i_blc_user.press(1, 60);
      chk({radio_pwr, lamp_en}, 2'b10);
      chk(led.blue, 1'b1);
      // Status word: awake, radio and blue on, no scan, no link
      apb(1'b0, 8'h04, 32'h0);
      chk({rd[6], rd[4:0]}, 6'h25);
      sys_flags.link_up <= 1'b1;
      per(1, 16);
      sys_flags.link_err <= 1'b1;
      per(1, 8);
      sys_flags <= '0;
      apb(1'b1, 8'h00, 32'h4);
      @(posedge mclk);
      chk(radio_pwr, 1'b0);
      $display("test scan and radio done");
      fork
         i_blc_user.press(2, 6);
         cnt_rst();
      join
      chk(lo, 16);
      chk(rc, 0);
      fork
         apb(1'b1, 8'h00, 32'h2);
         cnt_rst();
      join
      chk(lo, 16);
      chk(rc, 1);
      $display("test resets done");
      finish_test();
   end
endmodule

`default_nettype wire
